/* File: hw/cc_framer_pkg.sv */
// constants and carrier types for the completion stream straddle framer
// Operation
// RQ1 - error completions send a 3-Dword descriptor plus five request Dwords
// RQ2 - error completion packet is exactly eight Dwords long
// RQ3 - fourth Dword holds byte enables, hint flag, hint type, steering tag
// RQ4 - Dwords five to eight repeat the four request descriptor Dwords
// RQ5 - appended request information fills the header log
// RQ6 - second completion may start in a beat if first ends by Dword 7
// RQ7 - straddle is build-time and only with Dword-aligned placement
// RQ8 - straddle delimits by sideband flags and pointers, not keep and last
// RQ9 - first start flag marks a beginning at lane 0 or lane 32
// RQ10 - first start pointer is 2'b00 or 2'b10
// RQ11 - second start flag only for two starts, needing first end flag
// RQ12 - second start pointer is always 2'b10
// RQ13 - first end flag in every ending beat, pointer gives last Dword
// RQ14 - second end flag only with first end and first start flags
// RQ15 - second end pointer lies between 10 and 15
// RQ16 - payload follows its descriptor with no gap Dwords
// RQ17 - valid held for whole packet; drop mid-packet nullifies the completion
// RQ18 - last marks final beat; data and last stable while ready low
// RQ19 - discontinue is sticky for the packet and nullifies the completion
// RQ20 - beat is sixteen Dwords; pointers count Dwords from lane 0
// RQ21 - illegal flag or pointer combinations are malformed, never emitted
package cc_framer_pkg;
    localparam int BEAT_W = 32'h200;
    localparam int DW_W = 32'h20;
    localparam int DW_PER_BEAT = 32'h10;
    localparam logic [3:0] SECOND_BASE_DW = 4'h8;
    localparam logic [3:0] FIRST_HALF_LAST_DW = 4'h7;
    localparam logic [3:0] SECOND_MIN_END_DW = 4'hA;
    localparam logic [3:0] ERR_LEN_M1 = 4'h7;
    localparam logic [1:0] PTR_DW0 = 2'b00;
    localparam logic [1:0] PTR_DW8 = 2'b10;
    localparam logic [3:0] STATUS_DW = 4'h1;
    localparam int STATUS_LSB = 32'hB;
    localparam logic [2:0] STATUS_UR = 3'h1;
    localparam logic [2:0] STATUS_CA = 3'h4;
    localparam logic [3:0] SB_DW = 4'h3;
    localparam logic [3:0] REQ_DW0 = 4'h4;
    localparam logic [15:0] KEEP_ERR = 16'h00FF;
    localparam int LOG_DEPTH = 32'h4;
    localparam int LOG_AW = 32'h2;

    typedef struct packed {
        logic discontinue;
        logic [1:0] start_flags;
        logic [1:0] first_start_pointer;
        logic [1:0] second_start_pointer;
        logic [1:0] end_flags;
        logic [3:0] first_end_pointer;
        logic [3:0] second_end_pointer;
    } sideband_t;

    typedef struct packed {
        logic [1:0] done;
        logic [1:0] nullify;
        logic malformed;
        logic [1:0] logged;
    } report_t;

    typedef struct packed {
        logic [31:0] sideband_dw;
        logic [31:0] req_dw0;
        logic [31:0] req_dw1;
        logic [31:0] req_dw2;
        logic [31:0] req_dw3;
    } log_entry_t;
endpackage

/* File: hw/hdr_log_mem.sv */
// header log store: two write ports, registered read data
`timescale 1ns/1ps
module hdr_log_mem (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic we0_i,
    input wire logic [cc_framer_pkg::LOG_AW-1:0] wa0_i,
    input wire cc_framer_pkg::log_entry_t wd0_i,
    input wire logic we1_i,
    input wire logic [cc_framer_pkg::LOG_AW-1:0] wa1_i,
    input wire cc_framer_pkg::log_entry_t wd1_i,
    input wire logic [cc_framer_pkg::LOG_AW-1:0] ra_i,
    output cc_framer_pkg::log_entry_t rd_o
);
    cc_framer_pkg::log_entry_t mem_q [cc_framer_pkg::LOG_DEPTH];
    cc_framer_pkg::log_entry_t rd_q;

    // entries carry no reset: only the read register needs a defined value
    always_ff @(posedge mclk_i) begin
        if (we0_i) begin
            mem_q[wa0_i] <= wd0_i;
        end
        if (we1_i) begin
            mem_q[wa1_i] <= wd1_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem_q[ra_i];
        end
    end

    assign rd_o = rd_q;
endmodule

/* File: hw/completion_stream_straddle_framer.sv */
// completer completion stream framer with straddle delimiting and error log
`timescale 1ns/1ps
module completion_stream_straddle_framer #(
    parameter bit STRADDLE_EN = 1'b1,
    parameter bit ADDR_ALIGNED = 1'b0
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic completion_valid_i,
    input wire logic [cc_framer_pkg::BEAT_W-1:0] completion_payload_bus_i,
    input wire logic [cc_framer_pkg::DW_PER_BEAT-1:0] completion_keep_i,
    input wire logic completion_last_i,
    input wire cc_framer_pkg::sideband_t completion_sideband_bus_i,
    input wire logic [cc_framer_pkg::LOG_AW-1:0] log_rd_addr_i,
    output logic completion_ready_o,
    output cc_framer_pkg::report_t report_o,
    output cc_framer_pkg::log_entry_t log_rd_data_o,
    output logic [cc_framer_pkg::LOG_AW:0] log_count_o
);
    // straddle never combines with address-aligned placement
    localparam bit STRADDLE = STRADDLE_EN && !ADDR_ALIGNED; // [RQ7]

    typedef struct packed {
        logic ready;
        logic in_pkt;
        logic taint;
        logic disc;
        cc_framer_pkg::report_t rep;
        logic [cc_framer_pkg::LOG_AW-1:0] wr_ptr;
        logic [cc_framer_pkg::LOG_AW:0] count;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic we0;
    logic we1;
    logic [cc_framer_pkg::LOG_AW-1:0] wa1;
    cc_framer_pkg::log_entry_t wd0;
    cc_framer_pkg::log_entry_t wd1;

    // pointers count Dwords upward from byte lane 0
    function automatic logic [31:0] dword(
        input logic [cc_framer_pkg::BEAT_W-1:0] data,
        input logic [3:0] idx
    );
        return data[idx*cc_framer_pkg::DW_W +: cc_framer_pkg::DW_W]; // [RQ20]
    endfunction

    function automatic logic is_err_status(
        input logic [cc_framer_pkg::BEAT_W-1:0] data,
        input logic [3:0] base
    );
        logic [31:0] w;
        logic [2:0] st;
        w = dword(data, base + cc_framer_pkg::STATUS_DW);
        st = w[cc_framer_pkg::STATUS_LSB +: 3];
        return st == cc_framer_pkg::STATUS_UR
            || st == cc_framer_pkg::STATUS_CA;
    endfunction

    // descriptor in Dwords 0-2, sideband copy in 3, request Dwords in 4-7
    function automatic cc_framer_pkg::log_entry_t log_entry(
        input logic [cc_framer_pkg::BEAT_W-1:0] data,
        input logic [3:0] base
    );
        cc_framer_pkg::log_entry_t e;
        e.sideband_dw = dword(data, base + cc_framer_pkg::SB_DW); // [RQ3]
        e.req_dw0 = dword(data, base + cc_framer_pkg::REQ_DW0); // [RQ4]
        e.req_dw1 = dword(data, base + cc_framer_pkg::REQ_DW0 + 4'h1);
        e.req_dw2 = dword(data, base + cc_framer_pkg::REQ_DW0 + 4'h2);
        e.req_dw3 = dword(data, base + cc_framer_pkg::REQ_DW0 + 4'h3);
        return e;
    endfunction

    always_comb begin
        logic beat;
        logic sop0;
        logic sop1;
        logic eop0;
        logic eop1;
        logic [1:0] p0;
        logic [1:0] p1;
        logic [3:0] e0;
        logic [3:0] e1;
        logic bad;
        logic first_new;
        logic second;
        logic err0;
        logic err1;
        logic [cc_framer_pkg::LOG_AW:0] adds;
        logic disc_in;
        beat = completion_valid_i && s_q.ready;
        disc_in = completion_sideband_bus_i.discontinue;
        sop0 = completion_sideband_bus_i.start_flags[0];
        sop1 = completion_sideband_bus_i.start_flags[1];
        eop0 = completion_sideband_bus_i.end_flags[0];
        eop1 = completion_sideband_bus_i.end_flags[1];
        p0 = completion_sideband_bus_i.first_start_pointer;
        p1 = completion_sideband_bus_i.second_start_pointer;
        e0 = completion_sideband_bus_i.first_end_pointer;
        e1 = completion_sideband_bus_i.second_end_pointer;
        bad = 1'b0;
        first_new = 1'b0;
        second = 1'b0;
        err0 = 1'b0;
        err1 = 1'b0;
        adds = '0;
        s_d = s_q;
        s_d.ready = 1'b1;
        s_d.rep = '0;
        we0 = 1'b0;
        we1 = 1'b0;
        wd0 = '0;
        wd1 = '0;

        // a gap in valid inside a packet poisons that completion
        if (!completion_valid_i && s_q.in_pkt) begin
            s_d.taint = 1'b1; // [RQ17]
        end

        if (STRADDLE) begin
            // keep and last are not looked at in this mode
            if (sop0 && p0 != cc_framer_pkg::PTR_DW0
                     && p0 != cc_framer_pkg::PTR_DW8) begin
                bad = 1'b1; // [RQ10]
            end
            if (sop0 && p0 == cc_framer_pkg::PTR_DW0 && s_q.in_pkt) begin
                bad = 1'b1; // [RQ9]
            end
            if (sop0 && p0 == cc_framer_pkg::PTR_DW8
                     && !(s_q.in_pkt && eop0
                          && e0 <= cc_framer_pkg::FIRST_HALF_LAST_DW)) begin
                bad = 1'b1; // [RQ6] [RQ9]
            end
            if (sop1 && !(sop0 && p0 == cc_framer_pkg::PTR_DW0 && eop0
                          && p1 == cc_framer_pkg::PTR_DW8
                          && e0 <= cc_framer_pkg::FIRST_HALF_LAST_DW)) begin
                bad = 1'b1; // [RQ11] [RQ12]
            end
            if (eop1 && !(eop0 && sop0
                          && e1 >= cc_framer_pkg::SECOND_MIN_END_DW)) begin
                bad = 1'b1; // [RQ14] [RQ15]
            end
            if (eop1 && !((s_q.in_pkt && sop0) || sop1)) begin
                bad = 1'b1; // [RQ14]
            end
            if (!s_q.in_pkt && !sop0 && (eop0 || sop1)) begin
                bad = 1'b1; // [RQ13]
            end
            if (!s_q.in_pkt && sop0 && !eop0 && sop1) begin
                bad = 1'b1; // [RQ13]
            end
            first_new = !s_q.in_pkt && sop0;
            second = (s_q.in_pkt && sop0) || sop1; // [RQ8]
            // descriptors and payloads are contiguous, so an eight-Dword
            // error packet starting at Dword 0 or 8 fits in its own half
            err0 = first_new && eop0 && e0 == cc_framer_pkg::ERR_LEN_M1
                && is_err_status(completion_payload_bus_i, 4'h0); // [RQ2]
            err1 = second && eop1 // [RQ16]
                && e1 == cc_framer_pkg::SECOND_BASE_DW
                         + cc_framer_pkg::ERR_LEN_M1
                && is_err_status(completion_payload_bus_i,
                                 cc_framer_pkg::SECOND_BASE_DW); // [RQ2]
        end else begin
            first_new = !s_q.in_pkt;
            eop0 = completion_last_i;
            eop1 = 1'b0;
            err0 = first_new && completion_last_i
                && completion_keep_i == cc_framer_pkg::KEEP_ERR
                && is_err_status(completion_payload_bus_i, 4'h0); // [RQ2]
        end

        if (beat) begin
            if (bad) begin
                // drop the whole beat and resync on the next clean start
                s_d.rep.malformed = 1'b1; // [RQ21]
                s_d.in_pkt = 1'b0;
                s_d.taint = 1'b0;
                s_d.disc = 1'b0;
            end else begin
                if (eop0 && (s_q.in_pkt || first_new)) begin
                    s_d.rep.done[0] = 1'b1;
                    s_d.rep.nullify[0] = disc_in // [RQ17] [RQ19]
                        || (s_q.in_pkt && (s_q.taint || s_q.disc));
                    s_d.in_pkt = 1'b0;
                    s_d.taint = 1'b0;
                    s_d.disc = 1'b0;
                end else if (first_new || s_q.in_pkt) begin
                    s_d.in_pkt = 1'b1;
                    s_d.taint = s_q.in_pkt && s_q.taint;
                    s_d.disc = (s_q.in_pkt && s_q.disc)
                        || disc_in; // [RQ19]
                end
                if (second) begin
                    if (eop1) begin
                        s_d.rep.done[1] = 1'b1;
                        s_d.rep.nullify[1] = disc_in;
                    end else begin
                        s_d.in_pkt = 1'b1;
                        s_d.taint = 1'b0;
                        s_d.disc = disc_in;
                    end
                end
                // appended request details go to the header log
                we0 = err0; // [RQ1] [RQ5]
                we1 = err1; // [RQ5]
                wd0 = log_entry(completion_payload_bus_i, 4'h0);
                wd1 = log_entry(completion_payload_bus_i,
                                cc_framer_pkg::SECOND_BASE_DW);
                s_d.rep.logged = {err1, err0};
            end
        end

        // the log wraps: oldest entries are overwritten once it is full
        adds = {{cc_framer_pkg::LOG_AW{1'b0}}, we0}
             + {{cc_framer_pkg::LOG_AW{1'b0}}, we1};
        s_d.wr_ptr = s_q.wr_ptr + adds[cc_framer_pkg::LOG_AW-1:0];
        if (s_q.count + adds
                > (cc_framer_pkg::LOG_AW + 1)'(cc_framer_pkg::LOG_DEPTH)) begin
            s_d.count = (cc_framer_pkg::LOG_AW + 1)'(cc_framer_pkg::LOG_DEPTH);
        end else begin
            s_d.count = s_q.count + adds;
        end
    end

    assign wa1 = s_q.wr_ptr + {{(cc_framer_pkg::LOG_AW-1){1'b0}}, we0};

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    hdr_log_mem u_log (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .we0_i(we0),
        .wa0_i(s_q.wr_ptr),
        .wd0_i(wd0),
        .we1_i(we1),
        .wa1_i(wa1),
        .wd1_i(wd1),
        .ra_i(log_rd_addr_i),
        .rd_o(log_rd_data_o)
    );

    assign completion_ready_o = s_q.ready;
    assign report_o = s_q.rep;
    assign log_count_o = s_q.count;
endmodule

/* File: tb/cc_framer_monitor.sv */
// port checker for the completion stream straddle framer
`timescale 1ns/1ps
module cc_framer_monitor #(
    parameter bit STRADDLE_EN = 1'b1,
    parameter bit ADDR_ALIGNED = 1'b0
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic completion_valid_i,
    input wire cc_framer_pkg::sideband_t completion_sideband_bus_i,
    input wire logic completion_ready_o,
    input wire cc_framer_pkg::report_t report_o,
    input wire logic [cc_framer_pkg::LOG_AW:0] log_count_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    logic tk;
    logic two_ok;
    cc_framer_pkg::sideband_t sb;
    // flag rules only hold when straddle delimiting is in force
    assign tk = completion_valid_i && completion_ready_o && STRADDLE_EN
        && !ADDR_ALIGNED;
    assign sb = completion_sideband_bus_i;
    assign two_ok = tk && sb.start_flags == 2'h3 && sb.end_flags == 2'h3
        && sb.first_start_pointer == 2'h0 && sb.second_start_pointer == 2'h2
        && sb.first_end_pointer <= 4'h7 && sb.second_end_pointer >= 4'hA;
    a_ready_held: assert property (
        $past(nrst_i) |-> completion_ready_o)
        else $error("ready low outside reset");
    a_end_needs_flag: assert property (
        tk && sb.end_flags == 2'h0 |=> report_o.done == 2'h0)
        else $error("completion ended without end flag");
    a_pair_ends: assert property (
        two_ok |=> report_o.done == (report_o.malformed ? 2'h0 : 2'h3))
        else $error("straddled pair not both ended");
    a_end1_illegal: assert property (
        tk && sb.end_flags[1] && !(sb.end_flags[0] && sb.start_flags[0])
        |=> report_o.malformed)
        else $error("lone second end accepted");
    a_second_ptr: assert property (
        tk && sb.start_flags[1] && sb.second_start_pointer != 2'h2
        |=> report_o.malformed)
        else $error("bad second start pointer accepted");
    a_drop_clean: assert property (
        report_o.malformed |-> report_o.done == 2'h0 && report_o.logged == 2'h0)
        else $error("malformed beat produced output");
    a_abort_nullify: assert property (
        tk && sb.discontinue && sb.end_flags == 2'h1
        |=> report_o.nullify[0] || report_o.malformed)
        else $error("aborted completion not nullified");
    a_null_done: assert property (
        (report_o.nullify & ~report_o.done) == 2'h0)
        else $error("nullify without done");
    a_count_stable: assert property (
        report_o.logged == 2'h0 |-> $stable(log_count_o))
        else $error("log count moved without logging");
endmodule

bind completion_stream_straddle_framer cc_framer_monitor #(
    .STRADDLE_EN(STRADDLE_EN),
    .ADDR_ALIGNED(ADDR_ALIGNED)
) mon (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .completion_valid_i(completion_valid_i),
    .completion_sideband_bus_i(completion_sideband_bus_i),
    .completion_ready_o(completion_ready_o),
    .report_o(report_o),
    .log_count_o(log_count_o)
);

/* File: tb/cc_source.sv */
// user-side source model of completion beats
`timescale 1ns/1ps
module cc_source (
    input wire logic mclk_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [cc_framer_pkg::BEAT_W-1:0] data_o,
    output logic [cc_framer_pkg::DW_PER_BEAT-1:0] keep_o,
    output logic last_o,
    output cc_framer_pkg::sideband_t sb_o
);
    int n;
    initial begin
        valid_o = 1'b0;
        data_o = '0;
        keep_o = '0;
        last_o = 1'b0;
        sb_o = '0;
    end
    task automatic send(input cc_framer_pkg::sideband_t sb,
        input logic [cc_framer_pkg::BEAT_W-1:0] d, input logic [15:0] k,
        input logic l);
        @(negedge mclk_i);
        valid_o = 1'b1;
        data_o = d;
        keep_o = k;
        last_o = l;
        sb_o = sb;
        n = 0;
        @(posedge mclk_i);
        // beat held until ready is seen high, or until 50 further cycles pass without it
        while (ready_i !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk_i);
        end
    endtask
    // released lines flip so stale values never look valid
    task automatic idle();
        @(negedge mclk_i);
        valid_o = 1'b0;
        data_o = ~data_o;
        keep_o = ~keep_o;
        last_o = ~last_o;
        sb_o = ~sb_o;
    endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the completion stream straddle framer
`timescale 1ns/1ps
module tb;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic valid, ready, last;
    logic [cc_framer_pkg::BEAT_W-1:0] data, d0;
    logic [15:0] keep;
    logic [1:0] rd_addr = 2'h0;
    logic [2:0] cnt;
    logic [31:0] lfsr_q = 32'hAACE8181;
    logic [31:0] r;
    logic [16:0] bad [5] = '{17'h00200, 17'h00130, 17'h0C530, 17'h06000,
        17'h0CB39};
    cc_framer_pkg::sideband_t sb;
    cc_framer_pkg::report_t rep;
    cc_framer_pkg::report_t rep_al;
    cc_framer_pkg::log_entry_t rd_data;
    int error_cnt = 0;
    int comparisons = 0;
    always #12.5 mclk_i = ~mclk_i;
    completion_stream_straddle_framer dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .completion_valid_i(valid), .completion_payload_bus_i(data),
        .completion_keep_i(keep), .completion_last_i(last),
        .completion_sideband_bus_i(sb), .log_rd_addr_i(rd_addr),
        .completion_ready_o(ready), .report_o(rep), .log_rd_data_o(rd_data),
        .log_count_o(cnt));
    // same stream into a copy built for address-aligned placement
    completion_stream_straddle_framer #(.ADDR_ALIGNED(1'b1)) dut_aligned (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .completion_valid_i(valid),
        .completion_payload_bus_i(data), .completion_keep_i(keep),
        .completion_last_i(last), .completion_sideband_bus_i(sb),
        .log_rd_addr_i(rd_addr), .completion_ready_o(), .report_o(rep_al),
        .log_rd_data_o(), .log_count_o());
    cc_source src (.mclk_i(mclk_i), .ready_i(ready), .valid_o(valid),
        .data_o(data), .keep_o(keep), .last_o(last), .sb_o(sb));
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0],
            lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction
    // status of slot 0 lands in Dword 1, of slot 1 in Dword 9
    function automatic logic [511:0] mkdata(input logic [2:0] s0, s1);
        logic [511:0] d;
        for (int i = 0; i < 16; i++) d[32*i +: 32] = rnd();
        d[43 +: 3] = s0;
        d[299 +: 3] = s1;
        return d;
    endfunction
    function automatic logic [159:0] exp_entry(input logic [511:0] d, int b);
        return {d[32*(b+3) +: 32], d[32*(b+4) +: 32], d[32*(b+5) +: 32],
            d[32*(b+6) +: 32], d[32*(b+7) +: 32]};
    endfunction
    task automatic cmp(input logic [159:0] g, e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkr(input logic [1:0] dn, nl, input logic ml,
        input logic [1:0] lg, input bit edge_w);
        // after idle we sit at the falling edge, where the pulse still stands
        if (!edge_w) #1;
        cmp(160'(rep), 160'({dn, nl, ml, lg}));
    endtask
    task automatic beat(input logic dc, input logic [1:0] sf, p0, p1, ef,
        input logic [3:0] e0, e1, input logic [511:0] d);
        logic [31:0] kr;
        // own draw, so the caller's random fields stay intact
        kr = rnd();
        src.send(cc_framer_pkg::sideband_t'({dc, sf, p0, p1, ef, e0, e1}), d,
            kr[15:0], kr[16]);
    endtask
    task automatic rd(input logic [1:0] a, input logic [159:0] e);
        @(negedge mclk_i);
        rd_addr = a;
        @(posedge mclk_i);
        #1;
        cmp(160'(rd_data), e);
    endtask
    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        #1;
        cmp(160'({ready, rep, cnt}), 160'h0);
        cmp(160'(rd_data), 160'h0);
        @(negedge mclk_i);
        nrst_i = 1'b1;
        @(posedge mclk_i);
        #1;
        cmp(160'(ready), 160'h1);
        $display("test reset done");
        d0 = mkdata(3'h1, 3'h0);
        beat(1'h0, 2'h1, 2'h0, 2'h0, 2'h1, 4'h7, 4'h0, d0);
        src.idle();
        chkr(2'h1, 2'h0, 1'h0, 2'h1, 1'b1);
        rd(2'h0, exp_entry(d0, 0));
        cmp(160'(cnt), 160'h1);
        d0 = mkdata(3'h0, 3'h4);
        beat(1'h0, 2'h3, 2'h0, 2'h2, 2'h3, 4'h5, 4'hF, d0);
        src.idle();
        chkr(2'h3, 2'h0, 1'h0, 2'h2, 1'b1);
        rd(2'h1, exp_entry(d0, 8));
        cmp(160'(cnt), 160'h2);
        // two error completions per beat: fills the log, then wraps it
        for (int i = 0; i < 2; i++) begin
            d0 = mkdata(3'h1, 3'h4);
            beat(1'h0, 2'h3, 2'h0, 2'h2, 2'h3, 4'h7, 4'hF, d0);
            src.idle();
            chkr(2'h3, 2'h0, 1'h0, 2'h3, 1'b1);
        end
        rd(2'h0, exp_entry(d0, 0));
        rd(2'h1, exp_entry(d0, 8));
        cmp(160'(cnt), 160'h4);
        $display("test error_log done");
        // long packet continues, ends at Dword 3, next starts at Dword 8
        beat(1'h0, 2'h1, 2'h0, 2'h0, 2'h0, 4'h0, 4'h0, mkdata(3'h0, 3'h0));
        beat(1'h0, 2'h1, 2'h2, 2'h0, 2'h1, 4'h3, 4'h0, mkdata(3'h0, 3'h0));
        chkr(2'h1, 2'h0, 1'h0, 2'h0, 1'b0);
        beat(1'h0, 2'h0, 2'h0, 2'h0, 2'h1, 4'h7, 4'h0, mkdata(3'h0, 3'h0));
        chkr(2'h1, 2'h0, 1'h0, 2'h0, 1'b0);
        src.idle();
        chkr(2'h1, 2'h0, 1'h0, 2'h0, 1'b1);
        $display("test continue done");
        beat(1'h1, 2'h1, 2'h0, 2'h0, 2'h0, 4'h0, 4'h0, mkdata(3'h0, 3'h0));
        beat(1'h0, 2'h0, 2'h0, 2'h0, 2'h1, 4'h2, 4'h0, mkdata(3'h0, 3'h0));
        chkr(2'h1, 2'h1, 1'h0, 2'h0, 1'b0);
        src.idle();
        chkr(2'h1, 2'h1, 1'h0, 2'h0, 1'b1);
        beat(1'h0, 2'h1, 2'h0, 2'h0, 2'h0, 4'h0, 4'h0, mkdata(3'h0, 3'h0));
        src.idle();
        chkr(2'h0, 2'h0, 1'h0, 2'h0, 1'b1);
        beat(1'h0, 2'h0, 2'h0, 2'h0, 2'h1, 4'h4, 4'h0, mkdata(3'h0, 3'h0));
        src.idle();
        chkr(2'h1, 2'h1, 1'h0, 2'h0, 1'b1);
        $display("test nullify done");
        for (int i = 0; i < 5; i++) begin
            src.send(cc_framer_pkg::sideband_t'(bad[i]), mkdata(3'h0, 3'h0),
                16'hFFFF, 1'h1);
            src.idle();
            chkr(2'h0, 2'h0, 1'h1, 2'h0, 1'b1);
        end
        $display("test malformed done");
        for (int i = 0; i < 24; i++) begin
            d0 = mkdata(3'h0, 3'h0);
            r = rnd();
            beat(1'h0, {r[4], 1'h1}, 2'h0, 2'h2, {r[4], 1'h1},
                {1'h0, r[2:0]},
                (r[7:5] > 3'h5) ? 4'hF : 4'hA + {1'h0, r[7:5]}, d0);
            src.idle();
            chkr({r[4], 1'h1}, 2'h0, 1'h0, 2'h0, 1'b1);
        end
        $display("test random done");
        // without straddle, keep and last frame the packet
        src.send(cc_framer_pkg::sideband_t'(17'h0), mkdata(3'h0, 3'h0),
            16'hFFFF, 1'h1);
        d0 = mkdata(3'h4, 3'h0);
        src.send(cc_framer_pkg::sideband_t'(17'h0), d0, 16'h00FF, 1'h1);
        #1;
        cmp(160'(rep_al), 160'({2'h1, 2'h0, 1'h0, 2'h1}));
        cmp(160'(rep), 160'h0);
        src.idle();
        $display("test aligned done");
        test_done();
    end
endmodule
